// file: dv/lsp_monitor.sv
// concurrent checks on the link between the host end and the controller end
`timescale 1ns/1ns
module lsp_monitor
  import lsp_pkg::*;
(
  input wire logic pclk, // clock
  input wire logic presetn, // async reset, active low
  input wire logic prim_wr, // primitive write pulse
  input wire prim_code_t prim_code, // primitive code
  input wire prim_type_t prim_type, // primitive type
  input wire logic cfg_wr, // configuration write pulse
  input wire logic [1:0] cfg_sel, // configuration selector
  input wire logic [15:0] cfg_data, // configuration data
  input wire logic ev_valid, // event pending
  input wire prim_code_t ev_code, // event code
  input wire prim_type_t ev_type, // event type
  input wire logic [7:0] ev_param, // event parameter
  input wire logic ev_ack, // event taken
  input wire logic irq // interrupt request
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic int_en_q;
  logic int_en_d;
  // shadow of the interrupt enable; stop wins over a same-cycle enable write
  assign int_en_d = (prim_wr && prim_code == P_STOP) ? 1'b0 :
    (cfg_wr && cfg_sel == CFG_INT_CTRL) ? cfg_data[0] : int_en_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_en_q <= 1'b0;
    end else begin
      int_en_q <= int_en_d;
    end
  end
  chk_host_types: assert property (prim_wr |-> prim_type inside {T_REQ, T_RESP})
    else $error("host sent a controller-only type");
  chk_ctrl_types: assert property (ev_valid |-> ev_type inside {T_IND, T_CONF})
    else $error("controller posted a host-only type");
  chk_disc_unconf: assert property (ev_valid && ev_code == P_DISC |-> ev_type == T_IND)
    else $error("disconnect posted as confirmation");
  chk_disc_noresp: assert property (prim_wr && prim_code == P_DISC |-> prim_type == T_REQ)
    else $error("disconnect sent as response");
  chk_data_nocmd: assert property (ev_valid |-> ev_code != P_DATA)
    else $error("data primitive posted through the register");
  chk_event_hold: assert property (ev_valid && !ev_ack |=>
    ev_valid && $stable(ev_code) && $stable(ev_type) && $stable(ev_param))
    else $error("pending event changed before it was taken");
  chk_ack_release: assert property (ev_ack |=> !ev_valid)
    else $error("event still pending after acknowledge");
  chk_prim_pulse: assert property (prim_wr |=> !prim_wr)
    else $error("primitive write longer than one cycle");
  chk_irq_post: assert property ($rose(ev_valid) && int_en_q |-> irq)
    else $error("no interrupt on posted event");
  chk_irq_cause: assert property (irq |-> int_en_q && (ev_valid || $past(ev_valid)))
    else $error("interrupt without enabled pending event");
  cov_confirm: cover property (ev_valid && ev_type == T_CONF);
  cov_disc_ind: cover property (ev_valid && ev_code == P_DISC && ev_type == T_IND);
  cov_irq: cover property ($rose(irq));
endmodule

// file: dv/tb_link_service_primitive_handler.sv
// self-checking bench: apb host end and controller end joined by the link
`timescale 1ns/1ns
module tb_link_service_primitive_handler;
  import lsp_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic pready, pslverr, e;
  logic x32_mode = 1'b0, rem_valid = 1'b0, rem_ok = 1'b0;
  prim_code_t rem_code = P_CONN;
  prim_type_t rem_type = T_REQ;
  logic [7:0] rem_param = 8'h00;
  logic [2:0] rx_nr = 3'h0;
  logic rx_sup_valid = 1'b0, tx_iframe_sent = 1'b0, tx_desc_acked = 1'b0;
  logic rx_desc_done = 1'b0, init_done = 1'b0;
  logic [23:0] rx_ring_base = 24'h001000, tx_ring_base = 24'h002000;
  logic rem_ready, init_fetch, link_enable, transparent, send_dm, loopback;
  logic status_wr, own_clear;
  logic [15:0] status_word, bus_control_register, sw_q;
  logic [2:0] tx_ack_count, outstanding;
  logic [23:0] current_rx_descriptor_ptr, current_tx_descriptor_ptr;
  int miscompares = 0, n_compared = 0, n_cyc = 0, k = 0;
  int n_fetch = 0, n_dm = 0, n_own = 0, n_stw = 0;
  lsp_if lnk();
  lsp_host i_lsp_host (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .lnk(lnk));
  lsp_ctrl i_lsp_ctrl (.pclk, .presetn, .lnk(lnk), .x32_mode, .rem_valid, .rem_code, .rem_type,
    .rem_ok, .rem_param, .rx_nr, .rx_sup_valid, .tx_iframe_sent, .tx_desc_acked, .rx_desc_done,
    .init_done, .rx_ring_base, .tx_ring_base, .rem_ready, .init_fetch, .link_enable,
    .transparent, .send_dm, .loopback, .status_wr, .status_word, .own_clear, .tx_ack_count,
    .outstanding, .current_rx_descriptor_ptr, .current_tx_descriptor_ptr, .bus_control_register);
  lsp_monitor i_lsp_monitor (.pclk, .presetn, .prim_wr(lnk.prim_wr), .prim_code(lnk.prim_code),
    .prim_type(lnk.prim_type), .cfg_wr(lnk.cfg_wr), .cfg_sel(lnk.cfg_sel),
    .cfg_data(lnk.cfg_data), .ev_valid(lnk.ev_valid), .ev_code(lnk.ev_code),
    .ev_type(lnk.ev_type), .ev_param(lnk.ev_param), .ev_ack(lnk.ev_ack), .irq(lnk.irq));
  always #50 pclk = ~pclk;
  // pulse counters, so one-cycle outputs are never missed; also the hang limit
  always @(posedge pclk) begin
    n_cyc++;
    n_fetch += int'(init_fetch);
    n_dm += int'(send_dm);
    n_own += int'(own_clear);
    n_stw += int'(status_wr);
    if (status_wr === 1'b1) sw_q = status_word;
    if (n_cyc == 3000) begin
      miscompares++;
      final_report();
    end
  end
  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", nm, exp, got);
      miscompares++;
    end
  endtask
  // one apb transfer; the request stands until pready is sampled high, for at most 16 cycles
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) chk("pready", 32'h1, 32'h0);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic er);
    apb(1'b1, a, d);
    chk("pslverr", {31'h0, er}, {31'h0, e});
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk("pslverr", 32'h0, {31'h0, e});
    chk("prdata", x, r);
  endtask
  task automatic cmd(input prim_code_t c, input prim_type_t t, input logic er);
    wr(A_CMD, {24'h0, 2'b00, t, c}, er);
  endtask
  task automatic ev(input prim_code_t c, input prim_type_t t, input logic [7:0] p);
    rd(A_EVT, {16'h0, p, 1'b0, t, c, 1'b1});
  endtask
  task automatic cfg(input logic [1:0] s, input logic [15:0] d, input logic er);
    wr(A_CFG, {d, 14'h0, s}, er);
  endtask
  // remote station event, offered once the controller has a free slot, or after 20 cycles without one
  task automatic remote(input prim_code_t c, input prim_type_t t, input logic ok,
    input logic [7:0] p);
    for (int i = 0; i < 20 && rem_ready !== 1'b1; i++) @(posedge pclk);
    @(posedge pclk);
    rem_valid <= 1'b1;
    rem_code <= c;
    rem_type <= t;
    rem_ok <= ok;
    rem_param <= p;
    @(posedge pclk);
    rem_valid <= 1'b0;
    @(posedge pclk);
  endtask
  // k: 0 frame received, 1 i frame sent, 2 tx acked, 3 rx done, 4 init fetched
  task automatic pls(input int k);
    @(posedge pclk);
    {init_done, rx_desc_done, tx_desc_acked, tx_iframe_sent, rx_sup_valid} <= 5'h1 << k;
    @(posedge pclk);
    {init_done, rx_desc_done, tx_desc_acked, tx_iframe_sent, rx_sup_valid} <= 5'h0;
  endtask
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rd(A_STAT, 32'h0);
    cmd(P_START, T_REQ, 1'b1);
    cmd(P_CONN, T_IND, 1'b1);
    rd(A_STAT, 32'h4);
    rd(A_STAT, 32'h0);
    cfg(CFG_BUS_CTRL, 16'h1234, 1'b0);
    cfg(CFG_INIT_LO, 16'h5678, 1'b0);
    cfg(CFG_INIT_HI, 16'h0012, 1'b0);
    cmd(P_INIT, T_REQ, 1'b0);
    cyc(3);
    chk("bus_ctrl", 32'h1234, {16'h0, bus_control_register});
    chk("init_fetch", 32'h1, n_fetch);
    pls(4);
    ev(P_INIT, T_CONF, 8'h00);
    rd(A_EVT, {24'h0, 1'b0, T_CONF, P_INIT, 1'b0});
    chk("rx_ptr", 32'h001000, {8'h0, current_rx_descriptor_ptr});
    cfg(CFG_INT_CTRL, 16'h0001, 1'b1);
    rd(A_STAT, 32'h5);
    cmd(P_START, T_REQ, 1'b0);
    cfg(CFG_INT_CTRL, 16'h0001, 1'b0);
    cmd(P_CONN, T_REQ, 1'b0);
    chk("link_enable", 32'h1, {31'h0, link_enable});
    remote(P_CONN, T_CONF, 1'b1, 8'h00);
    chk("irq", 32'h1, {31'h0, lnk.irq});
    rd(A_STAT, 32'hb);
    ev(P_CONN, T_CONF, 8'h00);
    cmd(P_DISC, T_REQ, 1'b0);
    cyc(3);
    k = n_dm;
    chk("ev_valid", 32'h0, {31'h0, lnk.ev_valid});
    cmd(P_DISC, T_REQ, 1'b0);
    cyc(3);
    chk("send_dm", k + 1, n_dm);
    rd(A_EVT, {24'h0, 1'b0, T_CONF, P_CONN, 1'b0});
    cmd(P_CONN, T_REQ, 1'b0);
    remote(P_CONN, T_CONF, 1'b0, 8'h5a);
    ev(P_DISC, T_IND, 8'h5a);
    remote(P_CONN, T_IND, 1'b1, 8'h00);
    ev(P_CONN, T_IND, 8'h00);
    cmd(P_CONN, T_RESP, 1'b0);
    remote(P_RESET, T_IND, 1'b1, 8'h00);
    ev(P_RESET, T_IND, 8'h00);
    cmd(P_RESET, T_RESP, 1'b0);
    rx_nr <= 3'h3;
    pls(0);
    repeat (5) pls(1);
    cyc(2);
    chk("tx_ack_count", 32'h3, {29'h0, tx_ack_count});
    chk("outstanding", 32'h2, {29'h0, outstanding});
    repeat (4) pls(1);
    rx_nr <= 3'h6;
    pls(0);
    cyc(2);
    chk("outstanding", 32'h3, {29'h0, outstanding});
    pls(2);
    pls(3);
    cyc(2);
    chk("own_clear", 32'h1, n_own);
    chk("tx_ptr", 32'h002008, {8'h0, current_tx_descriptor_ptr});
    chk("rx_ptr", 32'h001008, {8'h0, current_rx_descriptor_ptr});
    cmd(P_STAT, T_REQ, 1'b0);
    cyc(3);
    chk("status_wr", 32'h1, n_stw);
    chk("status_word", 32'hc6, {24'h0, sw_q[7:0]});
    remote(P_ERROR, T_IND, 1'b0, 8'h00);
    ev(P_ERROR, T_IND, 8'h00);
    cmd(P_DISC, T_REQ, 1'b0);
    cmd(P_XID, T_REQ, 1'b0);
    ev(P_DISC, T_IND, REASON_NOT_XID);
    remote(P_XID, T_IND, 1'b1, 8'h00);
    rd(A_EVT, {16'h0, REASON_NOT_XID, 1'b0, T_IND, P_DISC, 1'b0});
    x32_mode <= 1'b1;
    cmd(P_XID, T_REQ, 1'b0);
    remote(P_XID, T_CONF, 1'b1, 8'h00);
    ev(P_XID, T_CONF, 8'h00);
    cmd(P_TRANS, T_REQ, 1'b0);
    cmd(P_TEST, T_REQ, 1'b0);
    cyc(2);
    chk("trans_loop", 32'h3, {30'h0, transparent, loopback});
    cmd(P_STOP, T_REQ, 1'b0);
    cyc(2);
    chk("stopped", 32'h0, {29'h0, link_enable, transparent, loopback});
    apb(1'b0, 8'h10, 32'h0);
    chk("pslverr", 32'h1, {31'h0, e});
    final_report();
  end
endmodule

// file: src/lsp_ctrl.sv
// controller end: primitive interpreter, sequence counts and descriptor pointers
// Operation
// RULE_01 - tx ack count follows last received N(r)
// RULE_02 - outstanding frames are V(S) minus V(A)
// RULE_03 - keep 24-bit next rx/tx descriptor pointers
// RULE_04 - services: establish, reset, disconnect, data
// RULE_05 - host requests/responds; controller indicates/confirms
// RULE_06 - disconnect unconfirmed; all others confirmed
// RULE_07 - indicate remote attempts to change link state
// RULE_08 - host answers confirmed indications with response
// RULE_09 - confirm once remote answers host request
// RULE_10 - connection primitives go through command register
// RULE_11 - data primitives ride descriptor ownership flags
// RULE_12 - stop, init, start, transparent control primitives
// RULE_13 - error primitive; status primitive writes status
// RULE_14 - xid only in x32 mode; test loopback
// RULE_15 - host configures, builds block, then init
// RULE_16 - start only after init confirm, then interrupts
// RULE_17 - connect confirm or disconnect indication with reason
// RULE_18 - passive disconnect request sends dm, f clear
// RULE_19 - connect response establishes the link
// RULE_20 - clear ownership only after send and ack
// RULE_21 - interrupt on each posted primitive, when enabled
//
// The APB slave port and the register addresses are this design's own decisions.
`timescale 1ns/1ns
module lsp_ctrl
  import lsp_pkg::*;
(
  input wire logic pclk, // system clock
  input wire logic presetn, // async reset, active low
  lsp_if.ctrl lnk, // primitive link to the host
  input wire logic x32_mode, // identification exchange permitted
  input wire logic rem_valid, // remote station event pulse
  input wire prim_code_t rem_code, // remote event kind
  input wire prim_type_t rem_type, // T_IND attempt or T_CONF answer
  input wire logic rem_ok, // answer positive
  input wire logic [7:0] rem_param, // reason on failure
  input wire logic [2:0] rx_nr, // N(r) of received S or I frame
  input wire logic rx_sup_valid, // S or I frame received pulse
  input wire logic tx_iframe_sent, // I frame sent, advances V(S)
  input wire logic tx_desc_acked, // tx descriptor sent and acknowledged
  input wire logic rx_desc_done, // rx descriptor filled
  input wire logic init_done, // init block fetch finished
  input wire logic [23:0] rx_ring_base, // ring bases from init block
  input wire logic [23:0] tx_ring_base, // ring bases from init block
  output logic rem_ready, // slot free for a remote event
  output logic init_fetch, // start fetching the init block
  output logic link_enable, // link operation enabled
  output logic transparent, // transparent operation
  output logic send_dm, // send dm frame with f clear
  output logic loopback, // remote loopback test active
  output logic status_wr, // write chip status to status buffer
  output logic [15:0] status_word, // status written
  output logic own_clear, // clear tx descriptor ownership flag
  output logic [2:0] tx_ack_count, // V(A)
  output logic [2:0] outstanding, // unacknowledged I frames
  output logic [23:0] current_rx_descriptor_ptr, // next rx descriptor
  output logic [23:0] current_tx_descriptor_ptr, // next tx descriptor
  output logic [15:0] bus_control_register // bus settings
);
  typedef enum logic [2:0] {
    S_STOPPED, S_INIT, S_IDLE, S_CONNECTING, S_CONNECTED, S_RESETTING, S_XID
  } st_t;
  st_t st_q, st_d;
  logic [2:0] va_q, vs_q, out_q;
  logic [23:0] rxp_q, txp_q;
  logic [15:0] busc_q, ilo_q, ihi_q, intc_q, stw_q;
  logic ev_v_q, irq_q, rdy_q, fetch_q, en_q, tr_q, dm_q, lb_q, stat_q, own_q;
  prim_code_t ev_c_q;
  prim_type_t ev_t_q;
  logic [7:0] ev_p_q;
  // decode of host commands and remote events
  wire cmd = lnk.prim_wr;
  wire is_req = cmd && lnk.prim_type == T_REQ; // [RULE_05]
  wire is_resp = cmd && lnk.prim_type == T_RESP; // [RULE_05]
  wire rq_stop = is_req && lnk.prim_code == P_STOP; // [RULE_12]
  wire rq_init = is_req && lnk.prim_code == P_INIT && st_q == S_STOPPED; // [RULE_12]
  wire rq_start = is_req && lnk.prim_code == P_START && st_q == S_IDLE && !en_q; // [RULE_12]
  wire rq_trans = is_req && lnk.prim_code == P_TRANS && en_q; // [RULE_12]
  wire rq_stat = is_req && lnk.prim_code == P_STAT; // [RULE_13]
  wire rq_test = is_req && lnk.prim_code == P_TEST && en_q; // [RULE_14]
  wire rq_conn = is_req && lnk.prim_code == P_CONN && en_q && st_q == S_IDLE; // [RULE_10]
  wire rq_disc = is_req && lnk.prim_code == P_DISC && en_q; // [RULE_10]
  wire rq_reset = is_req && lnk.prim_code == P_RESET && st_q == S_CONNECTED; // [RULE_04]
  wire rq_xid = is_req && lnk.prim_code == P_XID && en_q && st_q == S_IDLE; // [RULE_14]
  wire rs_conn = is_resp && lnk.prim_code == P_CONN && st_q == S_CONNECTING; // [RULE_19]
  wire rs_reset = is_resp && lnk.prim_code == P_RESET && st_q == S_RESETTING;
  wire slot_free = !ev_v_q || lnk.ev_ack;
  wire rem_take = rem_valid && rdy_q && en_q;
  // xid from the remote is refused outside x32 mode and never indicated
  wire rem_drop = rem_code == P_XID && !x32_mode; // [RULE_14]
  wire init_post = init_done && st_q == S_INIT && slot_free;
  wire xid_post = rq_xid && !x32_mode && slot_free;
  wire post = (rem_take && !rem_drop) || init_post || xid_post;
  wire rem_fail = rem_type == T_CONF && !rem_ok;
  // a failed confirmed service reports as disconnect indication plus reason
  wire prim_code_t post_c = init_post ? P_INIT : (xid_post || rem_fail) ? P_DISC : rem_code;
  wire prim_type_t post_t = (init_post || (!xid_post && rem_type == T_CONF && rem_ok))
    ? T_CONF : T_IND; // [RULE_17]
  wire [7:0] post_p = init_post ? REASON_NONE : xid_post ? REASON_NOT_XID : rem_param;
  // state machine for link phases
  always_comb begin
    st_d = st_q;
    if (rq_stop) begin
      st_d = S_STOPPED; // [RULE_12]
    end else if (rq_init) begin
      st_d = S_INIT; // [RULE_12]
    end else if (init_post) begin
      st_d = S_IDLE;
    end else if (rq_conn) begin
      st_d = S_CONNECTING; // [RULE_17]
    end else if (rq_reset) begin
      st_d = S_RESETTING;
    end else if (rq_xid && x32_mode) begin
      st_d = S_XID;
    end else if (rq_disc) begin
      st_d = S_IDLE; // [RULE_06] no confirmation follows
    end else if (rs_conn || rs_reset) begin
      st_d = S_CONNECTED; // [RULE_19]
    end else if (rem_take && !rem_drop) begin
      unique case (rem_type)
        T_CONF: st_d = (rem_ok && rem_code != P_XID && rem_code != P_TEST)
          ? S_CONNECTED : S_IDLE; // [RULE_17]
        T_IND: begin
          if (rem_code == P_DISC) begin
            st_d = S_IDLE;
          end else if (rem_code == P_CONN) begin
            st_d = S_CONNECTING; // awaits connect response
          end else if (rem_code == P_RESET) begin
            st_d = S_RESETTING; // awaits reset response
          end
        end
        default: st_d = st_q;
      endcase
    end
  end
  // phase, enables and controller-originated primitive slot
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= S_STOPPED;
      en_q <= 1'b0;
      tr_q <= 1'b0;
      lb_q <= 1'b0;
      ev_v_q <= 1'b0;
      ev_c_q <= P_CONN;
      ev_t_q <= T_IND;
      ev_p_q <= REASON_NONE;
    end else begin
      st_q <= st_d;
      en_q <= rq_stop ? 1'b0 : (rq_start ? 1'b1 : en_q); // [RULE_12]
      tr_q <= rq_stop ? 1'b0 : (rq_trans ? 1'b1 : tr_q); // [RULE_12]
      lb_q <= rq_stop ? 1'b0 : (rq_test ? 1'b1 : (rem_take && rem_code == P_TEST ? 1'b0 : lb_q));
      if (post) begin
        ev_v_q <= 1'b1; // [RULE_07] [RULE_09]
        ev_c_q <= post_c;
        ev_t_q <= post_t;
        ev_p_q <= post_p; // [RULE_17] reason in parameter field
      end else if (lnk.ev_ack) begin
        ev_v_q <= 1'b0;
      end
    end
  end
  // one-cycle control pulses toward the link and memory engines, plus the status word and the rem_ready and irq levels
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fetch_q <= 1'b0;
      dm_q <= 1'b0;
      stat_q <= 1'b0;
      own_q <= 1'b0;
      stw_q <= CFG_RST;
      rdy_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      fetch_q <= rq_init; // [RULE_12]
      dm_q <= rq_disc && st_q == S_IDLE; // [RULE_18]
      stat_q <= rq_stat; // [RULE_13]
      stw_q <= {5'h00, st_q, va_q, vs_q, en_q, tr_q};
      own_q <= tx_desc_acked; // [RULE_20] [RULE_11]
      // one slot only: a pending primitive holds off the next remote event
      rdy_q <= !post && slot_free;
      irq_q <= intc_q[0] && en_q && (post || (ev_v_q && !lnk.ev_ack)); // [RULE_21]
    end
  end
  // sequence counts; V(A) tracks latest N(r)
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      va_q <= 3'h0;
      vs_q <= 3'h0;
      out_q <= 3'h0;
    end else begin
      if (rx_sup_valid) begin
        va_q <= rx_nr; // [RULE_01]
      end
      if (tx_iframe_sent) begin
        vs_q <= vs_q + 3'h1;
      end
      out_q <= vs_q - va_q; // [RULE_02] modulo 8 wraps naturally
    end
  end
  // descriptor pointers and configuration written over the link
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rxp_q <= PTR_RST;
      txp_q <= PTR_RST;
      busc_q <= CFG_RST;
      ilo_q <= CFG_RST;
      ihi_q <= CFG_RST;
      intc_q <= CFG_RST;
    end else begin
      if (init_post) begin
        rxp_q <= rx_ring_base; // [RULE_03]
        txp_q <= tx_ring_base; // [RULE_03]
      end else begin
        rxp_q <= rx_desc_done ? rxp_q + DESC_STEP : rxp_q; // [RULE_03]
        txp_q <= tx_desc_acked ? txp_q + DESC_STEP : txp_q; // [RULE_03]
      end
      if (lnk.cfg_wr && lnk.cfg_sel == CFG_BUS_CTRL) busc_q <= lnk.cfg_data;
      if (lnk.cfg_wr && lnk.cfg_sel == CFG_INIT_LO) ilo_q <= lnk.cfg_data;
      if (lnk.cfg_wr && lnk.cfg_sel == CFG_INIT_HI) ihi_q <= lnk.cfg_data;
      // stop clears interrupt enable; a write in the same cycle loses
      if (rq_stop) begin
        intc_q <= CFG_RST;
      end else if (lnk.cfg_wr && lnk.cfg_sel == CFG_INT_CTRL) begin
        intc_q <= lnk.cfg_data;
      end
    end
  end
  // outputs straight from flops
  assign lnk.ev_valid = ev_v_q;
  assign lnk.ev_code = ev_c_q;
  assign lnk.ev_type = ev_t_q;
  assign lnk.ev_param = ev_p_q;
  assign lnk.irq = irq_q;
  assign rem_ready = rdy_q;
  assign init_fetch = fetch_q;
  assign link_enable = en_q;
  assign transparent = tr_q;
  assign send_dm = dm_q;
  assign loopback = lb_q;
  assign status_wr = stat_q;
  assign status_word = stw_q;
  assign own_clear = own_q;
  assign tx_ack_count = va_q;
  assign outstanding = out_q;
  assign current_rx_descriptor_ptr = rxp_q;
  assign current_tx_descriptor_ptr = txp_q;
  assign bus_control_register = busc_q;
endmodule

// file: src/lsp_host.sv
// host end: apb register front issuing requests and responses
`timescale 1ns/1ns
module lsp_host
  import lsp_pkg::*;
(
  input wire logic pclk, // system clock
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped or refused
  lsp_if.host lnk // primitive link to the controller
);
  logic rdy_q, err_q, pw_q, cw_q, ack_q, initc_q, started_q, ref_q;
  logic [31:0] rd_q;
  prim_code_t pc_q;
  prim_type_t pt_q;
  logic [7:0] pp_q;
  logic [1:0] cs_q;
  logic [15:0] cd_q;
  // apb decode; answer one cycle into the access phase
  wire acc = psel && penable && !rdy_q;
  wire hit_cmd = paddr == A_CMD;
  wire hit_evt = paddr == A_EVT;
  wire hit_cfg = paddr == A_CFG;
  wire hit_st = paddr == A_STAT;
  wire mapped = hit_cmd || hit_evt || hit_cfg || hit_st;
  wire prim_code_t w_code = prim_code_t'(pwdata[CMD_CODE_LSB +: 4]);
  wire prim_type_t w_type = prim_type_t'(pwdata[CMD_TYPE_LSB +: 2]);
  wire [1:0] w_sel = pwdata[CFG_SEL_LSB +: 2];
  // host may only originate requests and responses
  wire bad_type = w_type == T_IND || w_type == T_CONF; // [RULE_05]
  // start waits for the init confirmation; interrupts wait for start
  wire early_start = w_code == P_START && !initc_q; // [RULE_16]
  wire early_int = w_sel == CFG_INT_CTRL && !started_q; // [RULE_16]
  wire cmd_ok = acc && pwrite && hit_cmd && !bad_type && !early_start;
  wire cfg_ok = acc && pwrite && hit_cfg && !early_int;
  wire refuse = acc && pwrite && ((hit_cmd && (bad_type || early_start)) ||
    (hit_cfg && early_int));
  wire pop = acc && !pwrite && hit_evt && lnk.ev_valid;
  wire [31:0] rd_d = hit_evt ? {16'h0000, lnk.ev_param, 1'b0, lnk.ev_type, lnk.ev_code,
    lnk.ev_valid} : hit_st ? {28'h0000000, lnk.irq, ref_q, started_q, initc_q} : 32'h00000000;
  // apb answer and read data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdy_q <= 1'b0;
      err_q <= 1'b0;
      rd_q <= 32'h00000000;
    end else begin
      rdy_q <= acc;
      err_q <= acc && (!mapped || refuse);
      rd_q <= (acc && !pwrite) ? rd_d : rd_q;
    end
  end
  // commands toward the controller, one pulse per accepted write; event ack, one pulse per popping read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pw_q <= 1'b0;
      cw_q <= 1'b0;
      ack_q <= 1'b0;
      pc_q <= P_CONN;
      pt_q <= T_REQ;
      pp_q <= REASON_NONE;
      cs_q <= CFG_BUS_CTRL;
      cd_q <= CFG_RST;
    end else begin
      pw_q <= cmd_ok; // [RULE_10]
      cw_q <= cfg_ok; // [RULE_15]
      ack_q <= pop;
      if (cmd_ok) begin
        pc_q <= w_code;
        pt_q <= w_type;
        pp_q <= pwdata[CMD_PARAM_LSB +: 8];
      end
      if (cfg_ok) begin
        cs_q <= w_sel;
        cd_q <= pwdata[CFG_DATA_LSB +: 16];
      end
    end
  end
  // sequencing flags tracked from observed primitives
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      initc_q <= 1'b0;
      started_q <= 1'b0;
      ref_q <= 1'b0;
    end else begin
      if (pw_q && pc_q == P_STOP) begin
        initc_q <= 1'b0;
        started_q <= 1'b0;
      end else begin
        if (pop && lnk.ev_code == P_INIT && lnk.ev_type == T_CONF) initc_q <= 1'b1; // [RULE_16]
        if (pw_q && pc_q == P_START) started_q <= 1'b1;
      end
      ref_q <= refuse ? 1'b1 : ((acc && !pwrite && hit_st) ? 1'b0 : ref_q);
    end
  end
  assign prdata = rd_q;
  assign pready = rdy_q;
  assign pslverr = err_q;
  assign lnk.prim_wr = pw_q;
  assign lnk.prim_code = pc_q;
  assign lnk.prim_type = pt_q;
  assign lnk.prim_param = pp_q;
  assign lnk.cfg_wr = cw_q;
  assign lnk.cfg_sel = cs_q;
  assign lnk.cfg_data = cd_q;
  assign lnk.ev_ack = ack_q;
endmodule

// file: src/lsp_if.sv
// link between the host end and the controller end
`timescale 1ns/1ns
interface lsp_if;
  import lsp_pkg::*;
  logic prim_wr; // host -> ctrl: primitive command register write pulse
  prim_code_t prim_code;
  prim_type_t prim_type;
  logic [7:0] prim_param;
  logic cfg_wr; // host -> ctrl: configuration write pulse
  logic [1:0] cfg_sel;
  logic [15:0] cfg_data;
  logic ev_valid; // ctrl -> host: indication/confirmation pending
  prim_code_t ev_code;
  prim_type_t ev_type;
  logic [7:0] ev_param;
  logic ev_ack; // host -> ctrl: pending primitive taken
  logic irq; // ctrl -> host: interrupt request level
  modport ctrl (input prim_wr, prim_code, prim_type, prim_param, cfg_wr, cfg_sel,
    cfg_data, ev_ack, output ev_valid, ev_code, ev_type, ev_param, irq);
  modport host (output prim_wr, prim_code, prim_type, prim_param, cfg_wr, cfg_sel,
    cfg_data, ev_ack, input ev_valid, ev_code, ev_type, ev_param, irq);
endinterface

// file: src/lsp_pkg.sv
// shared constants and types for the link service primitive handler
package lsp_pkg;
  // primitive categories and vendor-added controls, 4-bit code
  typedef enum logic [3:0] {
    P_CONN, P_RESET, P_DISC, P_DATA, P_STOP, P_INIT, P_START,
    P_TRANS, P_ERROR, P_STAT, P_XID, P_TEST
  } prim_code_t;
  // primitive types: host originates req/resp, controller ind/conf
  typedef enum logic [1:0] {
    T_REQ, T_RESP, T_IND, T_CONF
  } prim_type_t;
  // configuration selectors for the controller's own registers
  localparam logic [1:0] CFG_BUS_CTRL = 2'h0;
  localparam logic [1:0] CFG_INIT_LO = 2'h1;
  localparam logic [1:0] CFG_INIT_HI = 2'h2;
  localparam logic [1:0] CFG_INT_CTRL = 2'h3;
  localparam int CFG_W = 16;
  localparam int PARAM_W = 8;
  localparam int PTR_W = 24;
  localparam int SEQ_W = 3;
  localparam logic [23:0] DESC_STEP = 24'h000008; // bytes per descriptor
  localparam logic [23:0] PTR_RST = 24'h000000;
  localparam logic [15:0] CFG_RST = 16'h0000;
  // reason codes placed in the primitive parameter field
  localparam logic [7:0] REASON_NONE = 8'h00;
  localparam logic [7:0] REASON_REFUSED = 8'h01;
  localparam logic [7:0] REASON_NOT_XID = 8'h02;
  // host-side apb register map
  localparam logic [7:0] A_CMD = 8'h00;
  localparam logic [7:0] A_EVT = 8'h04;
  localparam logic [7:0] A_CFG = 8'h08;
  localparam logic [7:0] A_STAT = 8'h0c;
  // field positions in the command and configuration registers
  localparam int CMD_CODE_LSB = 0;
  localparam int CMD_TYPE_LSB = 4;
  localparam int CMD_PARAM_LSB = 8;
  localparam int CFG_SEL_LSB = 0;
  localparam int CFG_DATA_LSB = 16;
endpackage
